// ---- common/pinmux_pkg.sv ----
// Shared constants and types for the host-port and panel pin-function mux.
// Assumes a single 125 MHz system clock on both ends and synchronous pin inputs.
package pinmux_pkg;

    // Host port strap codes (three strap pins)
    localparam logic [2:0] STRAP_8080 = 3'b000;  // 00X
    localparam logic [2:0] STRAP_6800 = 3'b010;  // 01X
    localparam logic [2:0] STRAP_SPI3 = 3'b100;  // 3-wire serial
    localparam logic [2:0] STRAP_SPI4 = 3'b101;  // 4-wire serial
    localparam logic [2:0] STRAP_I2C = 3'b110;   // 11X

    // Host port modes after decode
    typedef enum logic [2:0] {
        MODE_8080 = 3'b000,
        MODE_6800 = 3'b001,
        MODE_SPI3 = 3'b010,
        MODE_SPI4 = 3'b011,
        MODE_I2C = 3'b100
    } host_mode_t;

    // Panel width setting
    localparam logic [1:0] PANEL_GPIO = 2'b11;
    localparam logic [1:0] PANEL_16 = 2'b10;
    localparam logic [1:0] PANEL_18 = 2'b01;
    localparam logic [1:0] PANEL_24 = 2'b00;
    localparam logic [1:0] PANEL_DEFAULT = PANEL_18;

    // Test pin patterns
    localparam logic [1:0] TEST_FLASH_FLOAT = 2'b01;

    // Reset filter: 256 oscillator clocks, counted on the system clock
    localparam int RESET_FILTER_CLOCKS = 256;
    localparam int RESET_CNT_W = 9;
    localparam logic [RESET_CNT_W-1:0] RESET_CNT_MAX = RESET_CNT_W'(RESET_FILTER_CLOCKS);

    // Host cycle record length
    localparam int HOST_DATA_W = 16;

    // Host-side cycle timing in system clocks
    localparam int HOST_STROBE_NS = 16;
    localparam int CLK_PERIOD_NS = 8;
    localparam int HOST_STROBE_CYCLES =
        (HOST_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HOST_STROBE_CNT = 4'(HOST_STROBE_CYCLES);

    // Strap decode shared by both ends
    function automatic host_mode_t decode_strap(input logic [2:0] strap);
        host_mode_t m;
        m = MODE_8080;
        if (strap[2:1] == STRAP_8080[2:1])
            m = MODE_8080;
        else if (strap[2:1] == STRAP_6800[2:1])
            m = MODE_6800;
        else if (strap == STRAP_SPI3)
            m = MODE_SPI3;
        else if (strap == STRAP_SPI4)
            m = MODE_SPI4;
        else
            m = MODE_I2C;
        return m;
    endfunction

endpackage

// ---- common/host_link_if.sv ----
// Interface between the host controller end and the device pin mux end.
// Two-way data pins carry in, out and active-low output enable per end.
interface host_link_if;
    import pinmux_pkg::*;
    // Parallel strobes driven by host
    logic select_n;
    logic read_enable;       // read strobe (8080) or enable (6800)
    logic write_rw;          // write strobe (8080) or direction (6800)
    logic cmd_data_select;
    // Host data bus, per-end drive
    logic [HOST_DATA_W-1:0] host_dout;
    logic [HOST_DATA_W-1:0] host_doe_n;
    logic [HOST_DATA_W-1:0] dev_dout;
    logic [HOST_DATA_W-1:0] dev_doe_n;
    logic [HOST_DATA_W-1:0] host_data_bus;  // resolved level
    // Device outputs
    logic wait_n;
    logic irq_n;

    // Resolve the shared wire: the driving end wins, undriven bits pull high
    always_comb
    begin
        for (int i = 0; i < HOST_DATA_W; i++)
            host_data_bus[i] = !dev_doe_n[i] ? dev_dout[i] : (!host_doe_n[i] ? host_dout[i] : 1'b1);
    end

    modport device (
        input select_n, read_enable, write_rw, cmd_data_select, host_data_bus,
        output dev_dout, dev_doe_n, wait_n, irq_n
    );
    modport host (
        input host_data_bus, wait_n, irq_n,
        output select_n, read_enable, write_rw, cmd_data_select, host_dout, host_doe_n
    );
endinterface

// ---- design/host_port_master.sv ----
// Host controller end: runs one parallel command or data cycle per request.
// Assumes the device end decodes the same strap value.
module host_port_master
    import pinmux_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    // Configuration
    input wire logic [2:0] HOST_PORT_STRAP,
    // Requests
    input wire logic REQ,
    input wire logic REQ_WRITE,
    input wire logic REQ_CMD_DATA,
    input wire logic [HOST_DATA_W-1:0] REQ_DATA,
    output logic BUSY,
    output logic DONE,
    output logic [HOST_DATA_W-1:0] RD_DATA,
    output logic IRQ_PENDING,
    // Link
    host_link_if.host LINK
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_STROBE = 2'b10,
        ST_END = 2'b11
    } hstate_t;

    typedef struct packed {
        hstate_t st;
        logic [3:0] cnt;
        logic wr;
        logic cd;
        logic [HOST_DATA_W-1:0] data;
        logic [HOST_DATA_W-1:0] rd;
        logic done;
    } hreg_t;

    hreg_t r;        // Registered state
    hreg_t next_r;   // Next state
    host_mode_t mode;
    logic is_6800;

    assign mode = decode_strap(HOST_PORT_STRAP);
    assign is_6800 = (mode == MODE_6800);

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        unique case (r.st)
            ST_IDLE:
            begin
                // Only parallel modes start a cycle here
                if (REQ && (mode == MODE_8080 || is_6800))
                begin
                    next_r.st = ST_SETUP;
                    next_r.wr = REQ_WRITE;
                    next_r.cd = REQ_CMD_DATA;
                    next_r.data = REQ_DATA;
                    next_r.cnt = HOST_STROBE_CNT;
                end
            end
            ST_SETUP:
                next_r.st = ST_STROBE;
            ST_STROBE:
            begin
                // Hold the strobe for its minimum, then while wait is low
                if (r.cnt != 4'h0)
                    next_r.cnt = r.cnt - 4'h1;
                else if (LINK.wait_n)
                begin
                    next_r.rd = LINK.host_data_bus;
                    next_r.st = ST_END;
                end
            end
            ST_END:
            begin
                next_r.st = ST_IDLE;
                next_r.done = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            r <= '0;
        else if (CE)
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    logic active;
    logic strobe;
    assign active = (r.st != ST_IDLE);
    assign strobe = (r.st == ST_STROBE);

    assign LINK.select_n = !active;
    assign LINK.cmd_data_select = r.cd;
    // 8080: low read strobe; 6800: high enable
    assign LINK.read_enable = is_6800 ? strobe : !(strobe && !r.wr);
    // 8080: low write pulse 6800: direction held all cycle
    assign LINK.write_rw = is_6800 ? !r.wr : !(strobe && r.wr);
    assign LINK.host_dout = r.data;
    assign LINK.host_doe_n = {HOST_DATA_W{!(active && r.wr)}};

    assign BUSY = active;
    assign DONE = r.done;
    assign RD_DATA = r.rd;
    assign IRQ_PENDING = !LINK.irq_n;

endmodule

// ---- design/pin_function_mux.sv ----
// Device end: host port decode, serial pin reuse, panel bus mapping,
// general ports, key matrix gating, test overrides and reset filter.
// Assumes all pin inputs are synchronous to CLK_SYS.
module pin_function_mux
    import pinmux_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    // Straps and test pins
    input wire logic [2:0] HOST_PORT_STRAP,
    input wire logic [2:0] TEST_PINS,
    // Core configuration and status
    input wire logic [1:0] PANEL_WIDTH,
    input wire logic PULSE_ENABLE,
    input wire logic FLASH_MASTER_ENABLE,
    input wire logic CORE_CLOCK_SELECT,
    input wire logic CORE_CLOCK,
    input wire logic CORE_BUSY,
    input wire logic [7:0] STATUS_EVENTS,
    input wire logic [7:0] STATUS_MASK,
    input wire logic IRQ_CLEAR,
    input wire logic [HOST_DATA_W-1:0] CORE_READ_DATA,
    // Host cycle results
    output logic HOST_WRITE_STROBE,
    output logic HOST_WRITE_CD,
    output logic [HOST_DATA_W-1:0] HOST_WRITE_DATA,
    output logic [2:0] HOST_MODE,
    output logic [3:0] GENERAL_IN_GROUP_B,
    output logic [6:0] I2C_ADDR_STRAP,
    output logic SERIAL_CLOCK,
    output logic SERIAL_DATA_IN,
    output logic SERIAL_SELECT_N,
    input wire logic SERIAL_DATA_OUT,
    input wire logic SERIAL_DATA_OE_N,
    // General port A (upper host data byte)
    input wire logic [7:0] GENERAL_PORT_A_OUT,
    input wire logic [7:0] GENERAL_PORT_A_OE_N,
    output logic [7:0] GENERAL_PORT_A_IN,
    output logic GENERAL_PORT_A_AVAIL,
    // Panel pixel bus
    input wire logic [7:0] PIXEL_RED,
    input wire logic [7:0] PIXEL_GREEN,
    input wire logic [7:0] PIXEL_BLUE,
    input wire logic [23:0] PANEL_GPIO_OUT,
    output logic [23:0] PANEL_PIXEL_BUS,
    output logic [23:0] PANEL_PIXEL_OE_N,
    input wire logic [23:0] PANEL_PIXEL_IN,
    // General port D and key matrix
    input wire logic [7:0] GENERAL_PORT_D_OUT,
    output logic [7:0] GENERAL_PORT_D_AVAIL,
    input wire logic [4:0] KEY_STROBE_DRIVE,
    output logic [4:0] KEY_STROBE_OUT,
    output logic [4:0] KEY_STROBE_OE_N,
    output logic [4:0] KEY_SENSE_IN,
    output logic KEY_MATRIX_ENABLE,
    // Pulse pins, port C, flash master
    input wire logic PULSE0_OUT,
    input wire logic PULSE0_PIN_IN,
    output logic PULSE0_PIN_OUT,
    output logic PULSE0_PIN_OE_N,
    input wire logic [7:0] GENERAL_PORT_C_OUT,
    input wire logic [7:0] GENERAL_PORT_C_DIR_OUT,
    output logic [7:0] GENERAL_PORT_C_IN,
    output logic GENERAL_PORT_C_AVAIL,
    output logic BOOT_DISPLAY_STRAP,
    output logic FLASH_MASTER_FLOAT,
    output logic EXT_CLOCK_SELECT,
    // Filtered reset
    output logic CORE_RESET_N,
    // Link
    host_link_if.device LINK
);

    typedef struct packed {
        logic strobe_prev;                 // Write strobe active last cycle
        logic wr_pulse;
        logic cd;
        logic [HOST_DATA_W-1:0] wdata;
        logic [7:0] pending;               // Sticky status
        logic boot_display;
        logic boot_taken;
        logic [HOST_DATA_W-1:0] rdata;
    } dreg_t;
    dreg_t r;       // Registered state
    dreg_t next_r;  // Next state
    host_mode_t mode;
    logic parallel;
    logic serial;
    logic wide16;
    logic write_active;
    logic read_active;

    ////////////////////////////////////////////////////////////////////////
    // Host mode decode and strobe meaning
    assign mode = decode_strap(HOST_PORT_STRAP);
    assign parallel = (mode == MODE_8080) || (mode == MODE_6800);
    assign serial = !parallel;
    // No separate width strap here; a parallel port uses all sixteen bits
    assign wide16 = parallel;

    // 8080: low write and read strobes; 6800: high enable qualified by direction
    assign write_active = !LINK.select_n && !LINK.write_rw &&
        (mode == MODE_8080 || (mode == MODE_6800 && LINK.read_enable));
    assign read_active = !LINK.select_n && (mode == MODE_8080 ? !LINK.read_enable :
        (mode == MODE_6800 && LINK.read_enable && LINK.write_rw));

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_r = r;
        next_r.wr_pulse = 1'b0;
        next_r.strobe_prev = write_active;
        // Capture the data on every cycle the strobe is active
        if (write_active)
        begin
            next_r.wdata = LINK.host_data_bus;
            next_r.cd = LINK.cmd_data_select;
        end
        if (r.strobe_prev && !write_active)
            next_r.wr_pulse = 1'b1;
        // Read data latched at strobe start for a stable bus
        if (!read_active)
            next_r.rdata = CORE_READ_DATA;
        // Sticky status: a new event wins over the clear
        next_r.pending = (IRQ_CLEAR ? 8'h00 : r.pending) | STATUS_EVENTS;
        // Boot display sampled once after reset release
        if (!r.boot_taken)
        begin
            next_r.boot_display = PULSE0_PIN_IN;
            next_r.boot_taken = 1'b1;
        end
    end

    // State register; reset filter runs even while CE is low
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            r <= '0;
        else if (CE)
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset filter on the raw pin, counted in its own clocked process
    logic [RESET_CNT_W-1:0] rst_cnt;
    logic core_rst_n;
    always_ff @(posedge CLK_SYS)
    begin
        if (RST_N)
        begin
            rst_cnt <= '0;
            core_rst_n <= 1'b1;
        end
        else if (rst_cnt == RESET_CNT_MAX - 9'h001)
            core_rst_n <= 1'b0;
        else
            rst_cnt <= rst_cnt + 9'h001;
    end
    assign CORE_RESET_N = core_rst_n;

    ////////////////////////////////////////////////////////////////////////
    // Host pins
    assign LINK.wait_n = !(parallel && CORE_BUSY);
    assign LINK.irq_n = !(|(r.pending & STATUS_MASK));
    assign HOST_WRITE_STROBE = r.wr_pulse;
    assign HOST_WRITE_CD = r.cd;
    assign HOST_WRITE_DATA = r.wdata;
    assign HOST_MODE = mode;
    // Control pins as read-only inputs in serial mode
    assign GENERAL_IN_GROUP_B = serial ? {LINK.cmd_data_select, LINK.write_rw,
                                          LINK.read_enable, LINK.select_n} : 4'h0;
    // Serial pin meaning
    assign SERIAL_CLOCK = serial & LINK.host_data_bus[7];
    assign SERIAL_DATA_IN = (mode == MODE_SPI3) ? LINK.host_data_bus[5] : LINK.host_data_bus[6];
    assign SERIAL_SELECT_N = !(mode == MODE_SPI3 || mode == MODE_SPI4) | LINK.host_data_bus[4];
    assign I2C_ADDR_STRAP = {1'b0, LINK.host_data_bus[5:0]};
    // Port A when upper byte is free
    assign GENERAL_PORT_A_AVAIL = !wide16;
    assign GENERAL_PORT_A_IN = LINK.host_data_bus[15:8];

    always_comb
    begin
        LINK.dev_dout = {GENERAL_PORT_A_OUT, r.rdata[7:0]};
        LINK.dev_doe_n = '1;
        if (parallel && read_active)
        begin
            LINK.dev_dout = r.rdata;
            LINK.dev_doe_n = '0;
        end
        if (!wide16)
            LINK.dev_doe_n[15:8] = GENERAL_PORT_A_OE_N;
        if (mode == MODE_SPI3 || mode == MODE_SPI4)
        begin
            LINK.dev_dout[5] = SERIAL_DATA_OUT;
            LINK.dev_doe_n[5] = SERIAL_DATA_OE_N;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel bus mapping
    always_comb
    begin
        PANEL_PIXEL_BUS = PANEL_GPIO_OUT;
        PANEL_PIXEL_OE_N = '0;
        unique case (PANEL_WIDTH)
            PANEL_24:
                PANEL_PIXEL_BUS = {PIXEL_RED, PIXEL_GREEN, PIXEL_BLUE};
            PANEL_16:
            begin
                PANEL_PIXEL_BUS[7:3] = PIXEL_BLUE[7:3];
                PANEL_PIXEL_BUS[15:10] = PIXEL_GREEN[7:2];
                PANEL_PIXEL_BUS[23:19] = PIXEL_RED[7:3];
            end
            PANEL_18:
            begin
                PANEL_PIXEL_BUS[7:2] = PIXEL_BLUE[7:2];
                PANEL_PIXEL_BUS[15:10] = PIXEL_GREEN[7:2];
                PANEL_PIXEL_BUS[23:18] = PIXEL_RED[7:2];
            end
            PANEL_GPIO:
                PANEL_PIXEL_BUS = PANEL_GPIO_OUT;
        endcase
    end

    // Port D and key matrix gating
    assign GENERAL_PORT_D_AVAIL = {{2{PANEL_WIDTH == PANEL_16}},
                                   {6{PANEL_WIDTH == PANEL_16 || PANEL_WIDTH == PANEL_18}}};
    assign KEY_MATRIX_ENABLE = (PANEL_WIDTH != PANEL_24);
    // Open-drain: drive low or release
    assign KEY_STROBE_OUT = 5'h00;
    assign KEY_STROBE_OE_N = KEY_MATRIX_ENABLE ? KEY_STROBE_DRIVE : 5'h1f;
    // Unpressed key reads high through the pull-up
    assign KEY_SENSE_IN = KEY_MATRIX_ENABLE ?
        {PANEL_PIXEL_IN[2], PANEL_PIXEL_IN[8], PANEL_PIXEL_IN[1], PANEL_PIXEL_IN[0], 1'b1} : 5'h1f;

    ////////////////////////////////////////////////////////////////////////
    // Pulse pin, port C, test overrides
    assign GENERAL_PORT_C_AVAIL = !PULSE_ENABLE && !FLASH_MASTER_ENABLE;
    assign GENERAL_PORT_C_IN = GENERAL_PORT_C_AVAIL ? {PULSE0_PIN_IN, 7'h00} : 8'h00;
    // Bit 7 is an input unless set to output or core clock
    assign PULSE0_PIN_OUT = !GENERAL_PORT_C_AVAIL ? PULSE0_OUT : (CORE_CLOCK_SELECT ? CORE_CLOCK : GENERAL_PORT_C_OUT[7]);
    assign PULSE0_PIN_OE_N = GENERAL_PORT_C_AVAIL ? !(CORE_CLOCK_SELECT || GENERAL_PORT_C_DIR_OUT[7]) : !PULSE_ENABLE;
    assign BOOT_DISPLAY_STRAP = r.boot_display;
    assign EXT_CLOCK_SELECT = TEST_PINS[0];
    assign FLASH_MASTER_FLOAT = (TEST_PINS[2:1] == TEST_FLASH_FLOAT);

endmodule

// ---- test/pinmux_link_sva.sv ----
// Checker for the host link between the controller end and the pin mux end.
// Assumes one clock domain; sees the link lines and two device results.
module pinmux_link_sva
    import pinmux_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Link lines
    input wire logic select_n,
    input wire logic read_enable,
    input wire logic write_rw,
    input wire logic cmd_data_select,
    input wire logic [HOST_DATA_W-1:0] host_dout,
    input wire logic [HOST_DATA_W-1:0] host_doe_n,
    input wire logic [HOST_DATA_W-1:0] dev_doe_n,
    input wire logic wait_n,
    // Device results
    input wire logic [2:0] HOST_MODE,
    input wire logic HOST_WRITE_STROBE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    // Serial modes reuse the lines, so most checks hold in parallel modes only
    wire par = (HOST_MODE == 3'h0) || (HOST_MODE == 3'h1);
    wire m80 = HOST_MODE == 3'h0;
    wire dev_on = dev_doe_n != '1;
    ////////////////////////////////////////
    a_one_bus_driver:
        assert property (&(dev_doe_n | host_doe_n)) else $error("Both ends drive the data bus");
    a_dev_in_cycle:
        assert property (par && dev_on |-> !select_n || !$past(select_n)) else $error("Device drives out of a cycle");
    a_cd_held:
        assert property (par && !select_n && !$past(select_n) |-> $stable(cmd_data_select))
        else $error("Command/data select moved in a cycle");
    a_wdata_held:
        assert property (par && !select_n && !$past(select_n) && host_doe_n == '0 |-> $stable(host_dout))
        else $error("Write data moved in a cycle");
    a_cycle_min_len:
        assert property (par && $fell(select_n) |-> !select_n [*3]) else $error("Host cycle too short");
    a_cycle_bounded:
        assert property ($fell(select_n) |-> ##[1:60] select_n) else $error("Host cycle never ends");
    a_wait_extends:
        assert property (par && !wait_n && !select_n |=> !select_n) else $error("Cycle ended during wait");
    a_dir_held:
        assert property (HOST_MODE == 3'h1 && !select_n && !$past(select_n) |-> $stable(write_rw))
        else $error("Direction moved in a cycle");
    a_no_rd_wr:
        assert property (m80 |-> read_enable || write_rw) else $error("Read and write strobes both low");
    a_strobe_in_cycle:
        assert property (par && (m80 ? !write_rw : read_enable) |-> !select_n) else $error("Strobe outside select");
    a_write_latched:
        assert property (m80 && $rose(write_rw) && !$past(select_n) |-> ##[1:3] HOST_WRITE_STROBE)
        else $error("Write not latched at release");
    // Main scenarios
    c_wait: cover property (par && !wait_n && !select_n);
    c_write_6800: cover property (HOST_MODE == 3'h1 && HOST_WRITE_STROBE);
    c_dev_read: cover property (par && dev_on);
endmodule

// ---- test/host_and_panel_pin_function_mux_bench.sv ----
// Bench joining both ends over the link; random and corner traffic.
// Assumes one 125 MHz clock and the reset filter counted on it.
module host_and_panel_pin_function_mux_bench
    import pinmux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Driven side
    logic CLK_SYS = 1'b0, RST_N = 1'b0, CE = 1'b1;
    logic req = 1'b0, wr = 1'b0, cd = 1'b0, busy_in = 1'b0, clr = 1'b0, boot = 1'b1, got_c;
    logic [2:0] strap = 3'h0, tst = 3'h0;
    logic [1:0] pw = 2'h1;
    logic [7:0] ev = 8'h00, msk = 8'h00;
    logic [15:0] wdat = 16'h0000, cdat = 16'h0000, got_d;
    logic [127:0] r = '0;
    // Seen side
    logic done, irqp, hws, hcd, sclk, pav, kme, pcav, boot_s, ffl, ecs, crn;
    logic [15:0] hdat, rdd;
    logic [2:0] mode;
    logic [3:0] grpb;
    logic [6:0] i2c_addr_strap;
    logic [23:0] pbus, m;
    logic [7:0] pdav;
    logic [4:0] kso, koe;
    int seed = 32'hd41a1867;
    int fails = 0, n_checks = 0, nws = 0, lat, i;
    ////////////////////////////////////////
    host_link_if i_link();
    host_port_master i_host_port_master (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .HOST_PORT_STRAP(strap),
        .REQ(req), .REQ_WRITE(wr), .REQ_CMD_DATA(cd), .REQ_DATA(wdat), .BUSY(), .DONE(done), .RD_DATA(rdd),
        .IRQ_PENDING(irqp), .LINK(i_link));
    pin_function_mux i_pin_function_mux (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .HOST_PORT_STRAP(strap),
        .TEST_PINS(tst), .PANEL_WIDTH(pw), .PULSE_ENABLE(r[53]), .FLASH_MASTER_ENABLE(r[54]),
        .CORE_CLOCK_SELECT(r[55]), .CORE_CLOCK(r[56]), .CORE_BUSY(busy_in), .STATUS_EVENTS(ev),
        .STATUS_MASK(msk), .IRQ_CLEAR(clr), .CORE_READ_DATA(cdat), .HOST_WRITE_STROBE(hws), .HOST_WRITE_CD(hcd),
        .HOST_WRITE_DATA(hdat), .HOST_MODE(mode), .GENERAL_IN_GROUP_B(grpb), .I2C_ADDR_STRAP(i2c_addr_strap),
        .SERIAL_CLOCK(sclk), .SERIAL_DATA_IN(), .SERIAL_SELECT_N(), .SERIAL_DATA_OUT(r[57]),
        .SERIAL_DATA_OE_N(r[58]), .GENERAL_PORT_A_OUT(r[66:59]), .GENERAL_PORT_A_OE_N(r[74:67]),
        .GENERAL_PORT_A_IN(), .GENERAL_PORT_A_AVAIL(pav), .PIXEL_RED(r[23:16]), .PIXEL_GREEN(r[15:8]),
        .PIXEL_BLUE(r[7:0]), .PANEL_GPIO_OUT(r[47:24]), .PANEL_PIXEL_BUS(pbus), .PANEL_PIXEL_OE_N(),
        .PANEL_PIXEL_IN(r[98:75]), .GENERAL_PORT_D_OUT(r[106:99]), .GENERAL_PORT_D_AVAIL(pdav),
        .KEY_STROBE_DRIVE(r[52:48]), .KEY_STROBE_OUT(kso), .KEY_STROBE_OE_N(koe), .KEY_SENSE_IN(),
        .KEY_MATRIX_ENABLE(kme), .PULSE0_OUT(r[107]), .PULSE0_PIN_IN(boot), .PULSE0_PIN_OUT(),
        .PULSE0_PIN_OE_N(), .GENERAL_PORT_C_OUT(r[115:108]), .GENERAL_PORT_C_DIR_OUT(r[123:116]),
        .GENERAL_PORT_C_IN(), .GENERAL_PORT_C_AVAIL(pcav), .BOOT_DISPLAY_STRAP(boot_s),
        .FLASH_MASTER_FLOAT(ffl), .EXT_CLOCK_SELECT(ecs), .CORE_RESET_N(crn), .LINK(i_link));
    pinmux_link_sva i_pinmux_link_sva (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .select_n(i_link.select_n),
        .read_enable(i_link.read_enable), .write_rw(i_link.write_rw), .cmd_data_select(i_link.cmd_data_select),
        .host_dout(i_link.host_dout), .host_doe_n(i_link.host_doe_n), .dev_doe_n(i_link.dev_doe_n),
        .wait_n(i_link.wait_n), .HOST_MODE(mode), .HOST_WRITE_STROBE(hws));
    ////////////////////////////////////////
    always #4 CLK_SYS = ~CLK_SYS;
    // Fresh side inputs every cycle
    always @(posedge CLK_SYS) r <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    // Keep what the device latched from each write
    always @(posedge CLK_SYS)
        if (hws === 1'b1)
        begin
            got_d <= hdat;
            got_c <= hcd;
            nws <= nws + 1;
        end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Mode expected from the strap pins
    function automatic logic [2:0] exp_mode(input logic [2:0] s);
        if (!s[2])
            return s[1] ? 3'h1 : 3'h0;
        return s[1] ? 3'h4 : (s[0] ? 3'h3 : 3'h2);
    endfunction
    // One host cycle; the read answer is the same word that a write sends
    task automatic xfer(input logic [2:0] s, input logic w, input logic c, input logic [15:0] d);
        int n0;
        n0 = nws;
        @(posedge CLK_SYS);
        strap <= s;
        req <= 1'b1;
        wr <= w;
        cd <= c;
        wdat <= d;
        cdat <= d;
        @(posedge CLK_SYS);
        req <= 1'b0;
        lat = 0;
        do
        begin
            @(negedge CLK_SYS);
            lat++;
        end
        while (done !== 1'b1 && lat < 200);
        chk("done", 1, done);
        chk("latency", 1, lat >= 4);
        // The device's latched word reaches the bench one edge after DONE
        @(negedge CLK_SYS);
        if (w)
        begin
            chk("wdata", d, got_d);
            chk("wcd", c, got_c);
        end
        else
            chk("rdata", d, rdd);
        chk("pulses", n0 + w, nws);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (3) @(negedge CLK_SYS);
        chk("boot", 1, boot_s);
        for (i = 0; i < 16; i++)
            xfer(i[3] ? STRAP_6800 : STRAP_8080, i[0], i[1], i[2:1] == 2'h0 ? {16{i[0]}} : 16'($random(seed)));
        @(posedge CLK_SYS);
        busy_in <= 1'b1;
        boot <= 1'b0;
        fork
            xfer(STRAP_8080, 1'b1, 1'b1, 16'h5a5a);
            begin
                repeat (12) @(posedge CLK_SYS);
                busy_in <= 1'b0;
            end
        join
        chk("wait", 1, lat >= 11);
        for (i = 0; i < 8; i++)
        begin
            @(posedge CLK_SYS);
            strap <= i[2:0];
            tst <= i[2:0];
            pw <= i[1:0];
            @(negedge CLK_SYS);
            chk("mode", exp_mode(i[2:0]), mode);
            chk("port_a", i[2], pav);
            chk("group_b", i[2] ? {i_link.cmd_data_select, i_link.write_rw, i_link.read_enable,
                i_link.select_n} : 4'h0, grpb);
            if (i[2])
                chk("sclock", i_link.host_data_bus[7], sclk);
            if (i[2:1] == 2'h3)
                chk("i2c", {1'b0, i_link.host_data_bus[5:0]}, i2c_addr_strap);
            chk("ext_clock", i[0], ecs);
            chk("flash_float", i[2:1] == 2'h1, ffl);
            chk("port_c", !(r[53] | r[54]), pcav);
            m = i[1:0] == 2'h1 ? 24'hfcfcfc : (i[1:0] == 2'h2 ? 24'hf8fcf8 : 24'hffffff);
            chk("pixel", m & (i[1:0] == 2'h3 ? r[47:24] : r[23:0]), m & pbus);
            chk("keys_on", i[1:0] != 2'h0, kme);
            chk("port_d", i[1:0] == 2'h2 ? 8'hff : (i[1:0] == 2'h1 ? 8'h3f : 8'h00), pdav);
            chk("strobe", 0, kso);
            chk("strobe_oe", i[1:0] != 2'h0 ? r[52:48] : 5'h1f, koe);
        end
        // Masked event first, then an enabled one, then clear
        for (i = 0; i < 2; i++)
        begin
            @(posedge CLK_SYS);
            clr <= 1'b0;
            msk <= {7'h00, i[0]};
            ev <= 8'h01;
            @(posedge CLK_SYS);
            ev <= 8'h00;
            repeat (3) @(negedge CLK_SYS);
            chk("irq", i[0], irqp);
            @(posedge CLK_SYS);
            clr <= 1'b1;
        end
        @(posedge CLK_SYS);
        clr <= 1'b0;
        repeat (3) @(negedge CLK_SYS);
        chk("irq_clear", 0, irqp);
        @(posedge CLK_SYS);
        RST_N <= 1'b0;
        repeat (200) @(negedge CLK_SYS);
        chk("reset_short", 1, crn);
        repeat (100) @(negedge CLK_SYS);
        chk("reset_long", 0, crn);
        @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (3) @(negedge CLK_SYS);
        chk("boot_low", 0, boot_s);
        xfer(STRAP_6800, 1'b1, 1'b0, 16'h8001);
        wrap_up();
    end
    // A hang counts as a mismatch
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule
